/* rtl/msp_defs.svh */
// constants for the meter serial port
`ifndef MSP_DEFS_SVH
`define MSP_DEFS_SVH

`define MSP_ADDR_STATUS_CLR  7'h1A
`define MSP_ADDR_OPCTRL      7'h13
`define MSP_OPCTRL_SWRST_BIT 6
`define MSP_CMD_WRITE_BIT    7
`define MSP_STATUS_WIDTH     24
`define MSP_STATUS_RST_BIT   16
`define MSP_STATUS_RESET     24'h00_0000
`define MSP_FIFO_WIDTH       17
`define MSP_FIFO_DEPTH       16
`define MSP_MAX_BYTES        3

`endif

/* rtl/msp_pkg.sv */
// types and helpers for the meter serial port
`default_nettype none
package msp_pkg;
    typedef enum logic [1:0] {
        ST_CMD   = 2'b00,
        ST_LOAD  = 2'b01,
        ST_WRITE = 2'b10,
        ST_READ  = 2'b11
    } msp_state_t;

    // data bytes for a register of the given width, one to three
    function automatic logic [1:0] msp_byte_count(input logic [4:0] width);
        logic [5:0] sum;
        sum = {1'b0, width} + 6'h07;
        if (sum[5:3] == 3'h0) begin
            msp_byte_count = 2'h1;
        end else if (sum[5:3] > 3'h3) begin
            msp_byte_count = 2'h3;
        end else begin
            msp_byte_count = sum[4:3];
        end
    endfunction
endpackage
`default_nettype wire

/* rtl/msp_sync.sv */
// two flip-flop synchroniser for pin inputs
`default_nettype none
module msp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // asynchronous in, synchronised out
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] stage1_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            stage1_q <= '0;
            syncOut  <= '0;
        end else begin
            stage1_q <= asyncIn;
            syncOut  <= stage1_q;
        end
    end
endmodule
`default_nettype wire

/* rtl/msp_fifo.sv */
// synchronous fifo with valid and ready on both sides
`default_nettype none
module msp_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    wire              doPush = inValid && inReady;
    wire              doPop  = outValid && outReady;

    assign inReady  = count_q != DEPTH[AW:0];
    assign outValid = count_q != '0;
    assign outData  = mem[rdPtr_q];

    always_ff @(posedge mclk) begin
        if (doPush) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            wrPtr_q <= doPush ? wrPtr_q + 1'b1 : wrPtr_q;
            rdPtr_q <= doPop ? rdPtr_q + 1'b1 : rdPtr_q;
            count_q <= count_q + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop};
        end
    end
endmodule
`default_nettype wire

/* rtl/msp_serial_port.sv */
// serial slave port with interrupt line release timing
`include "msp_defs.svh"
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [RULE1] status read command end releases interrupt high
// [RULE2] hold release through status byte, then re-evaluate
// [RULE3] sample data input on falling serial clock
// [RULE4] launch output bits on rising serial clock
// [RULE5] chip select fall returns to command mode
// [RULE6] chip select rise aborts, output floats
// [RULE7] held-low select: finish transfers or soft reset
// [RULE8] first byte is command: direction and address
// [RULE9] write: data shifts in on following falls
// [RULE10] read: output driven from next rising edge
// [RULE11] last register bit ends transfer, command mode
// [RULE12] host spaces write bytes at least 900 ns
// [RULE13] aborted partial write byte is discarded
// [RULE14] up to three bytes, MSB first, right justified
// [RULE15] read end floats output at final fall
// [RULE16] read abort floats output at select rise
// [RULE17] whole register snapshot taken when addressed
// [RULE18] host waits 1.1 us from write to read
// [RULE19] host uses falling-edge interrupt and clearing read
// [RULE20] reset flag high for one clock only
// [RULE21] command bit 7 write, bits 0-6 address
// [RULE22] clearing register read returns and clears flags
// [RULE23] byte count from width; ignore clock when deselected
module msp_serial_port
    import msp_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // serial pins
    input  wire logic        sclk,
    input  wire logic        csN,
    input  wire logic        din,
    output logic             dout,
    output logic             doutOe,
    output logic             irqN,
    // register read side
    output logic [6:0]       regRdAddr,
    input  wire logic [4:0]  regRdWidth,
    input  wire logic [23:0] regRdData,
    // register write side, one byte per word
    output logic             regWrValid,
    input  wire logic        regWrReady,
    output logic [6:0]       regWrAddr,
    output logic [1:0]       regWrLane,
    output logic [7:0]       regWrData,
    // interrupt sources
    input  wire logic [23:0] statusEvent,
    input  wire logic [23:0] statusMask
);

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    logic [2:0] pinSync;
    logic       sclkPrev_q;
    logic       csPrev_q;

    msp_sync #(.W(3)) u_sync (
        .mclk    (mclk),
        .rst     (rst),
        .asyncIn ({sclk, csN, din}),
        .syncOut (pinSync)
    );

    wire sclkS  = pinSync[2];
    wire csHigh = pinSync[1];
    wire dinS   = pinSync[0];
    wire sRise  = sclkS && !sclkPrev_q && !csHigh; // RULE23
    wire sFall  = !sclkS && sclkPrev_q && !csHigh; // RULE3 RULE23
    wire csFall = !csHigh && csPrev_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            sclkPrev_q <= 1'b0;
            // matches the synchroniser's reset value, so no false select fall
            csPrev_q   <= 1'b0;
        end else begin
            sclkPrev_q <= sclkS;
            csPrev_q   <= csHigh;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // transfer state
    msp_state_t  state_q;
    logic [4:0]  bitCnt_q;
    logic [6:0]  cmdSh_q;
    logic [7:0]  cmd_q;
    logic [1:0]  nBytes_q;
    logic [23:0] shReg_q;
    logic        dout_q;
    logic        doutOe_q;
    logic        irqHold_q;
    logic        rstSeen_q;
    logic        rstPulse_q;
    logic [23:0] flags_q;
    logic        irqN_q;
    logic        pendValid_q;
    logic [16:0] pend_q;

    wire [7:0] cmdFull   = {cmdSh_q, dinS};
    wire       cmdIsWr   = cmd_q[`MSP_CMD_WRITE_BIT]; // RULE8 RULE21
    wire [6:0] cmdAddr   = cmd_q[6:0]; // RULE21
    wire       cmdDone   = state_q == ST_CMD && sFall && bitCnt_q == 5'h07;
    wire       clrRead   = cmdFull[7] == 1'b0 && cmdFull[6:0] == `MSP_ADDR_STATUS_CLR;
    wire [4:0] lastIdx   = {nBytes_q, 3'b000} - 5'h01;
    wire       lastBit   = bitCnt_q == lastIdx;
    wire       byteEnd   = bitCnt_q[2:0] == 3'h7;
    wire [7:0] wrByte    = {shReg_q[6:0], dinS};
    wire       wrByteEnd = state_q == ST_WRITE && sFall && byteEnd;
    wire       swReset   = wrByteEnd && lastBit && cmdAddr == `MSP_ADDR_OPCTRL
                           && wrByte[`MSP_OPCTRL_SWRST_BIT];
    wire       loadClr   = state_q == ST_LOAD && !cmdIsWr
                           && cmdAddr == `MSP_ADDR_STATUS_CLR; // RULE22
    wire [1:0] ldBytes   = msp_byte_count(regRdWidth); // RULE23
    wire [4:0] ldShift   = 5'd24 - {ldBytes, 3'b000};
    wire [23:0] ldValue  = loadClr ? flags_q : regRdData;

    // one serial state process, edges gated by chip select
    always_ff @(posedge mclk) begin
        if (rst || csHigh || csFall || swReset) begin // RULE5 RULE6 RULE7
            state_q  <= ST_CMD;
            bitCnt_q <= 5'h00;
        end else begin
            case (state_q)
                ST_CMD: begin
                    if (sFall) begin // RULE8
                        cmdSh_q  <= cmdFull[6:0];
                        bitCnt_q <= bitCnt_q + 5'h01;
                        if (cmdDone) begin
                            cmd_q    <= cmdFull;
                            state_q  <= ST_LOAD;
                            bitCnt_q <= 5'h00;
                        end
                    end
                end
                ST_LOAD: begin // RULE17
                    nBytes_q <= ldBytes;
                    shReg_q  <= ldValue << ldShift; // RULE14
                    state_q  <= cmdIsWr ? ST_WRITE : ST_READ; // RULE9 RULE10
                end
                ST_WRITE: begin
                    if (sFall) begin // RULE9
                        shReg_q  <= {shReg_q[22:0], dinS};
                        bitCnt_q <= bitCnt_q + 5'h01;
                        if (lastBit) begin // RULE11
                            state_q  <= ST_CMD;
                            bitCnt_q <= 5'h00;
                        end
                    end
                end
                ST_READ: begin
                    if (sRise) begin // RULE4
                        shReg_q <= {shReg_q[22:0], 1'b0};
                    end
                    if (sFall) begin
                        bitCnt_q <= bitCnt_q + 5'h01;
                        if (lastBit) begin // RULE11
                            state_q  <= ST_CMD;
                            bitCnt_q <= 5'h00;
                        end
                    end
                end
                default: begin
                    state_q  <= ST_CMD;
                    bitCnt_q <= 5'h00;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // serial output
    wire oeOn  = state_q == ST_READ && sRise; // RULE10
    wire oeOff = csHigh || (state_q == ST_READ && sFall && lastBit); // RULE15 RULE16

    always_ff @(posedge mclk) begin
        if (rst) begin
            dout_q   <= 1'b0;
            doutOe_q <= 1'b0;
        end else begin
            if (oeOn) begin
                dout_q <= shReg_q[23]; // RULE4
            end
            doutOe_q <= oeOff ? 1'b0 : (oeOn ? 1'b1 : doutOe_q);
        end
    end

    assign dout      = dout_q;
    assign doutOe    = doutOe_q;
    assign regRdAddr = cmdAddr;

    //////////////////////////////////////////////////////////////////////////
    // write bytes into the fifo; pending slot stalls on a full fifo
    logic        fifoInReady;
    logic [16:0] fifoOut;
    wire  [1:0]  wrLane = nBytes_q - 2'h1 - bitCnt_q[4:3]; // RULE14

    always_ff @(posedge mclk) begin
        if (rst) begin
            pendValid_q <= 1'b0;
            pend_q      <= 17'h0_0000;
        end else if (wrByteEnd) begin // RULE13
            pendValid_q <= 1'b1;
            pend_q      <= {cmdAddr, wrLane, wrByte};
        end else if (fifoInReady) begin
            pendValid_q <= 1'b0;
        end
    end

    msp_fifo #(
        .WIDTH (`MSP_FIFO_WIDTH),
        .DEPTH (`MSP_FIFO_DEPTH)
    ) u_fifo (
        .mclk     (mclk),
        .rst      (rst),
        .inValid  (pendValid_q),
        .inReady  (fifoInReady),
        .inData   (pend_q),
        .outValid (regWrValid),
        .outReady (regWrReady),
        .outData  (fifoOut)
    );

    assign regWrAddr = fifoOut[16:10];
    assign regWrLane = fifoOut[9:8];
    assign regWrData = fifoOut[7:0];

    //////////////////////////////////////////////////////////////////////////
    // status flags and interrupt line
    wire [23:0] rstBit    = 24'h00_0001 << `MSP_STATUS_RST_BIT;
    wire [23:0] flagsKeep = loadClr ? `MSP_STATUS_RESET : flags_q; // RULE22
    wire [23:0] flagsD    = ((flagsKeep | statusEvent) & ~rstBit)
                            | (rstPulse_q ? rstBit : 24'h00_0000); // RULE20
    wire holdSet = cmdDone && clrRead; // RULE1
    wire holdEnd = csHigh || csFall || swReset
                   || (state_q == ST_READ && sFall && bitCnt_q == 5'h07); // RULE2
    wire irqHoldD = holdSet ? 1'b1 : (holdEnd ? 1'b0 : irqHold_q);

    always_ff @(posedge mclk) begin
        if (rst) begin
            rstSeen_q  <= 1'b0;
            rstPulse_q <= 1'b0;
            flags_q    <= `MSP_STATUS_RESET;
            irqHold_q  <= 1'b0;
            irqN_q     <= 1'b1;
        end else begin
            rstSeen_q  <= !swReset;
            rstPulse_q <= !rstSeen_q; // RULE20
            flags_q    <= flagsD;
            irqHold_q  <= irqHoldD;
            irqN_q     <= irqHoldD || !(|(flagsD & statusMask)); // RULE1 RULE2
        end
    end

    assign irqN = irqN_q;

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_irq_hold_high: assert property (irqHold_q |-> irqN) // RULE2
        else $error("interrupt low during status hold");
    a_irq_release: assert property (holdSet |=> irqHold_q ##1 irqN) // RULE1
        else $error("interrupt not released at command end");
    a_sample_fall: assert property ((state_q == ST_WRITE && !sFall && !csHigh)
        |=> $stable(bitCnt_q)) // RULE3
        else $error("write bit counted without falling edge");
    a_launch_rise: assert property ($changed(dout_q) |-> $past(sRise)) // RULE4
        else $error("output bit changed without rising edge");
    a_cs_fall_cmd: assert property (csFall |=> state_q == ST_CMD
        && bitCnt_q == 5'h00) // RULE5
        else $error("select fall did not reset port");
    a_cs_high_float: assert property (csHigh |=> !doutOe && state_q == ST_CMD) // RULE6 RULE16
        else $error("output driven while deselected");
    a_read_end: assert property ((state_q == ST_READ && sFall && lastBit && !csFall)
        |=> !doutOe && state_q == ST_CMD) // RULE15
        else $error("read end did not float output");
    a_write_push: assert property ((wrByteEnd && !csFall) |=> pendValid_q
        && pend_q[7:0] == $past(wrByte)) // RULE9 RULE13
        else $error("completed write byte not queued");
    a_load_order: assert property (cmdDone && !csFall |=> state_q == ST_LOAD
        ##1 state_q inside {ST_WRITE, ST_READ}) // RULE8 RULE17
        else $error("command not followed by snapshot");
    a_reset_flag: assert property (flags_q[`MSP_STATUS_RST_BIT]
        |=> !flags_q[`MSP_STATUS_RST_BIT]) // RULE20
        else $error("reset flag held longer than one cycle");
    a_oe_rise: assert property ($rose(doutOe) |-> $past(oeOn)) // RULE10
        else $error("output enabled without read rising edge");
    a_byte_count: assert property ((state_q == ST_LOAD && !csHigh) // RULE23
        |=> nBytes_q == $past(ldBytes))
        else $error("byte count not taken from register width");
    a_swreset_cmd: assert property (swReset // RULE7
        |=> state_q == ST_CMD && bitCnt_q == 5'h00)
        else $error("software reset did not return to command mode");
endmodule
`default_nettype wire

/* sim/msp_host_model.sv */
// host-side serial master model for the meter serial port
`default_nettype none
module msp_host_model (
    // clock
    input  wire logic mclk,
    // serial pins
    output var logic  sclk,
    output var logic  csN,
    output var logic  din,
    input  wire logic doutPin
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        din = 1'b0;
    end

    // deselected data line keeps moving so no stale bit is read
    always @(negedge mclk) begin
        if (csN) begin
            din <= ~din;
        end
    end

    task automatic sel();
        @(negedge mclk);
        csN = 1'b0;
        repeat (3) @(negedge mclk);
    endtask

    // idle gap covers write-to-read spacing
    task automatic desel();
        @(negedge mclk);
        csN = 1'b1;
        repeat (12) @(negedge mclk);
    endtask

    // rise, 4 high, fall, 4 low: din steady around the fall
    task automatic xbit(input logic b, output logic r);
        @(negedge mclk);
        sclk = 1'b1;
        if (!csN) begin
            din = b;
        end
        repeat (4) @(negedge mclk);
        r = doutPin;
        sclk = 1'b0;
        repeat (3) @(negedge mclk);
    endtask

    // byte period of 6.4 us keeps write bytes well spaced
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            xbit(tx[i], rx[i]);
        end
    endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the meter serial port
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        mclk, rst, sclk, csN, din, dout, doutOe, irqN;
    logic [6:0]  regRdAddr, regWrAddr;
    logic [1:0]  regWrLane;
    logic [7:0]  regWrData;
    logic        regWrValid, regWrReady;
    logic [23:0] regRdData, statusEvent, statusMask;
    logic [4:0]  regRdWidth;
    logic [23:0] regMem [128];
    logic [16:0] got [$];
    wire         doutPin = doutOe ? dout : ~dout;
    int          comparisons, miscompares;

    assign regRdData = regMem[regRdAddr];
    assign regRdWidth = (regRdAddr == 7'h10) ? 5'h0C : ((regRdAddr == 7'h13) ? 5'h08 : 5'h18);

    msp_serial_port msp_serial_port_i (.mclk(mclk), .rst(rst), .sclk(sclk), .csN(csN),
        .din(din), .dout(dout), .doutOe(doutOe), .irqN(irqN), .regRdAddr(regRdAddr),
        .regRdWidth(regRdWidth), .regRdData(regRdData), .regWrValid(regWrValid),
        .regWrReady(regWrReady), .regWrAddr(regWrAddr), .regWrLane(regWrLane),
        .regWrData(regWrData), .statusEvent(statusEvent), .statusMask(statusMask));
    msp_host_model msp_host_model_i (.mclk(mclk), .sclk(sclk), .csN(csN), .din(din),
        .doutPin(doutPin));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // drained bytes land in the register model
    always @(posedge mclk) begin
        if (regWrValid && regWrReady) begin
            got.push_back({regWrAddr, regWrLane, regWrData});
            regMem[regWrAddr][regWrLane*8 +: 8] <= regWrData;
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chkVal(input logic [23:0] act, input logic [23:0] exp);
        comparisons++;
        if (act !== exp) begin
            miscompares++;
            $display("Error at %0t: value %h expected %h", $time, act, exp);
        end
    endtask

    task automatic chkWord(input logic [16:0] exp);
        int n;
        n = 0;
        while (got.size() == 0 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        if (got.size() == 0) begin
            miscompares++;
            $display("Error at %0t: no written byte", $time);
            report_and_stop();
        end else begin
            chkVal({7'h00, got.pop_front()}, {7'h00, exp});
        end
    endtask

    task automatic xfer(input logic [7:0] cmd, input int n, input logic [23:0] tx,
                        output logic [23:0] rx);
        logic [7:0] r;
        rx = 24'h00_0000;
        msp_host_model_i.xbyte(cmd, r);
        for (int i = n - 1; i >= 0; i--) begin
            msp_host_model_i.xbyte(tx[i*8 +: 8], r);
            rx[i*8 +: 8] = r;
        end
    endtask

    task automatic evt();
        statusEvent = 24'h00_0001;
        @(negedge mclk);
        statusEvent = 24'h00_0000;
    endtask

    task automatic t_write();
        logic [23:0] rx;
        regWrReady = 1'b0;
        msp_host_model_i.sel();
        xfer(8'hA0, 3, 24'h12_3456, rx);
        msp_host_model_i.desel();
        msp_host_model_i.sel();
        xfer(8'h90, 2, 24'h00_0ABC, rx);
        msp_host_model_i.desel();
        regWrReady = 1'b1;
        chkWord({7'h20, 2'h2, 8'h12});
        chkWord({7'h20, 2'h1, 8'h34});
        chkWord({7'h20, 2'h0, 8'h56});
        chkWord({7'h10, 2'h1, 8'h0A});
        chkWord({7'h10, 2'h0, 8'hBC});
    endtask

    task automatic t_read();
        logic [7:0]  r;
        logic [23:0] rx;
        regMem[7'h21] = 24'hA5_C33C;
        msp_host_model_i.sel();
        msp_host_model_i.xbyte(8'h21, r);
        chkVal({23'h00_0000, doutOe}, 24'h00_0000);
        @(negedge mclk);
        regMem[7'h21] = 24'h00_0000;
        for (int i = 2; i >= 0; i--) begin
            msp_host_model_i.xbyte(8'h00, r);
            rx[i*8 +: 8] = r;
        end
        chkVal(rx, 24'hA5_C33C);
        chkVal({23'h00_0000, doutOe}, 24'h00_0000);
        xfer(8'h20, 3, 24'h00_0000, rx);
        chkVal(rx, 24'h12_3456);
        msp_host_model_i.desel();
    endtask

    task automatic t_abort();
        logic        r;
        logic [7:0]  rb;
        logic [23:0] rx;
        msp_host_model_i.sel();
        msp_host_model_i.xbyte(8'hA0, rb);
        repeat (4) msp_host_model_i.xbit(1'b1, r);
        msp_host_model_i.desel();
        chkVal(24'(got.size()), 24'h00_0000);
        msp_host_model_i.xbyte(8'hA0, rb);
        msp_host_model_i.sel();
        msp_host_model_i.xbyte(8'h20, rb);
        repeat (4) msp_host_model_i.xbit(1'b0, r);
        chkVal({23'h00_0000, doutOe}, 24'h00_0001);
        msp_host_model_i.desel();
        chkVal({23'h00_0000, doutOe}, 24'h00_0000);
        msp_host_model_i.sel();
        xfer(8'h20, 3, 24'h00_0000, rx);
        chkVal(rx, 24'h12_3456);
        msp_host_model_i.desel();
    endtask

    task automatic t_irq();
        logic [7:0]  r;
        logic [23:0] rx;
        statusMask = 24'h00_0001;
        evt();
        repeat (5) @(negedge mclk);
        chkVal({23'h00_0000, irqN}, 24'h00_0000);
        msp_host_model_i.sel();
        msp_host_model_i.xbyte(8'h1A, r);
        chkVal({23'h00_0000, irqN}, 24'h00_0001);
        evt();
        msp_host_model_i.xbyte(8'h00, r);
        chkVal({16'h0000, r}, 24'h00_0000);
        repeat (3) @(negedge mclk);
        chkVal({23'h00_0000, irqN}, 24'h00_0000);
        xfer(8'h00, 1, 24'h00_0000, rx);
        chkVal(rx, 24'h00_0001);
        xfer(8'h1A, 3, 24'h00_0000, rx);
        chkVal(rx, 24'h00_0001);
        repeat (4) @(negedge mclk);
        chkVal({23'h00_0000, irqN}, 24'h00_0001);
        msp_host_model_i.desel();
    endtask

    task automatic t_swreset();
        logic [23:0] rx;
        msp_host_model_i.sel();
        xfer(8'h93, 1, 24'h00_0040, rx);
        chkWord({7'h13, 2'h0, 8'h40});
        repeat (12) @(negedge mclk);
        xfer(8'h20, 3, 24'h00_0000, rx);
        chkVal(rx, 24'h12_3456);
        msp_host_model_i.desel();
    endtask

    initial begin
        rst = 1'b1;
        regWrReady = 1'b1;
        statusEvent = 24'h00_0000;
        statusMask = 24'h00_0000;
        foreach (regMem[i]) regMem[i] = 24'h00_0000;
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        t_write();
        t_read();
        t_abort();
        t_irq();
        t_swreset();
        report_and_stop();
    end

    // hang guard
    initial begin
        repeat (90000) @(posedge mclk);
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
